// ==== rtl/pfa_program_flow.sv ====
// Purpose: Executes the loop, conditional call and accumulator move instructions
// Assumes: Frames come from a stored program or, when cmd_direct is high, from a host
// Notes: One frame per two cycles; motion itself runs outside
// Notes on behaviour
// - Code 49 decrements variable, jumps to value
// - Nonzero decremented result jumps, else sequential
// - Code 21 calls on twelve conditions
// - Types 8 to 11 test error flags
// - Types 0 to 7 use flags of last comparison
// - False call advances, stack untouched
// - True call pushes pc, loads target
// - Stack holds eight; full call ignored
// - Code 46 moves; type fixed/offset/stored
// - Offset move adds accumulator to position
// - Move selects position mode, loads target
// - Move replies at once, motor keeps running
// - Halt or spin aborts positioning move
`timescale 1ns/1ps
`include "pfa_regs.svh"
module pfa_program_flow (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Command frames
	input wire logic cmd_valid,
	input wire logic cmd_direct,
	input wire pfa_pkg::pfa_frame_t cmd_frame,
	output logic cmd_ready_reg,
	// Reply to the host
	output pfa_pkg::pfa_reply_t reply_reg,
	// Machine state from other instructions
	input wire pfa_pkg::pfa_flags_t flags,
	input wire logic [31:0] accum,
	input wire logic [31:0] act_pos,
	input wire logic [31:0] stored_point_type_pos,
	// User variable load port
	input wire logic var_wr_en,
	input wire logic [7:0] var_wr_idx,
	input wire logic [31:0] var_wr_data,
	// Motion controller hand-over
	input wire logic motor_halt_cmd,
	input wire logic spin_left_cmd,
	input wire logic spin_right_cmd,
	output logic [31:0] target_pos_reg,
	output logic pos_mode_reg,
	output logic move_start_reg,
	output logic moving_reg,
	// Program flow state
	output pfa_pkg::pfa_pc_t pc_reg,
	output logic [3:0] sp_reg,
	output logic [31:0] loop_var_reg
);
	pfa_pkg::pfa_state_t state_reg;
	pfa_pkg::pfa_frame_t cur_reg;
	logic direct_reg;
	logic [31:0] uvar_mem [0:255];
	pfa_pkg::pfa_pc_t stack_mem [0:7];
	logic exec, sum_ok, loop_ok, call_ok, move_ok, cond_ok, stack_full, do_push, do_jump;
	logic [31:0] dec_val, move_dst;
	logic [7:0] sum, status_next;
	pfa_pkg::pfa_pc_t pc_next, target;

	// Condition decode shared by call and its check
	function automatic logic cond_met(input logic [7:0] t, input pfa_pkg::pfa_flags_t f);
		case (t)
			`PFA_C_NULL: cond_met = f.zero;
			`PFA_C_NONNULL: cond_met = !f.zero;
			`PFA_C_SAME: cond_met = f.equal;
			`PFA_C_DIFFER: cond_met = !f.equal;
			`PFA_C_ABOVE: cond_met = f.greater;
			`PFA_C_ABOVE_SAME: cond_met = f.greater | f.equal;
			`PFA_C_BELOW: cond_met = f.lower;
			`PFA_C_BELOW_SAME: cond_met = f.lower | f.equal;
			`PFA_C_TIMEOUT: cond_met = f.timeout_err;
			`PFA_C_ALARM: cond_met = f.alarm_err;
			`PFA_C_DEVIATION: cond_met = f.deviation_err;
			`PFA_C_POSITION: cond_met = f.position_err;
			default: cond_met = 1'b0;
		endcase
	endfunction : cond_met

	// Frame checksum over the eight leading bytes
	assign sum = cur_reg.addr + cur_reg.instr + cur_reg.kind + cur_reg.bank + cur_reg.value[31:24]
		+ cur_reg.value[23:16] + cur_reg.value[15:8] + cur_reg.value[7:0];
	assign exec = (state_reg == pfa_pkg::PFA_EXEC);
	assign sum_ok = (sum == cur_reg.checksum);
	assign target = cur_reg.value[15:0];
	// Host may not drive loop or call; refusing keeps the stack sane
	assign loop_ok = exec && sum_ok && !direct_reg && cur_reg.instr == `PFA_OP_LOOP;
	assign call_ok = exec && sum_ok && !direct_reg && cur_reg.instr == `PFA_OP_CALL;
	assign move_ok = exec && sum_ok && cur_reg.instr == `PFA_OP_MOVE && cur_reg.kind <= `PFA_T_STORED;
	assign dec_val = uvar_mem[cur_reg.kind] - `PFA_VAR_STEP;
	assign cond_ok = cond_met(cur_reg.kind, flags);
	assign stack_full = (sp_reg >= `PFA_STACK_DEPTH);
	assign do_push = call_ok && cond_ok && !stack_full;
	// Nonzero test, so a negative count keeps looping like any other nonzero
	assign do_jump = do_push || (loop_ok && dec_val != `PFA_VAR_ZERO);

	// Destination of a move; 32-bit add wraps past half the range
	always_comb begin
		case (cur_reg.kind)
			`PFA_T_OFFSET: move_dst = act_pos + accum;
			`PFA_T_STORED: move_dst = stored_point_type_pos;
			default: move_dst = accum;
		endcase
	end

	// Next program counter; direct frames leave it alone
	always_comb begin
		if (do_jump) begin
			pc_next = target;
		end else if (exec && !direct_reg) begin
			pc_next = pc_reg + `PFA_PC_STEP;
		end else begin
			pc_next = pc_reg;
		end
	end

	// Reply status for direct frames
	always_comb begin
		if (!sum_ok) begin
			status_next = `PFA_ST_BAD_SUM;
		end else if (cur_reg.instr == `PFA_OP_LOOP || cur_reg.instr == `PFA_OP_CALL) begin
			status_next = `PFA_ST_NOT_AVAIL;
		end else if (cur_reg.instr != `PFA_OP_MOVE) begin
			status_next = `PFA_ST_BAD_CMD;
		end else if (!move_ok) begin
			status_next = `PFA_ST_BAD_TYPE;
		end else begin
			status_next = `PFA_ST_OK;
		end
	end

	// Two-state sequencer; ready returns right after execution
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= pfa_pkg::PFA_IDLE;
			cmd_ready_reg <= 1'b0;
		end else begin
			case (state_reg)
				pfa_pkg::PFA_IDLE: begin
					if (cmd_valid && cmd_ready_reg) begin
						state_reg <= pfa_pkg::PFA_EXEC;
						cmd_ready_reg <= 1'b0;
					end else begin
						cmd_ready_reg <= 1'b1;
					end
				end
				pfa_pkg::PFA_EXEC: begin
					state_reg <= pfa_pkg::PFA_IDLE;
					cmd_ready_reg <= 1'b1;
				end
				default: begin
					state_reg <= pfa_pkg::PFA_IDLE;
					cmd_ready_reg <= 1'b0;
				end
			endcase
		end
	end

	// Frame capture
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_reg <= '0;
			direct_reg <= 1'b0;
		end else if (cmd_valid && cmd_ready_reg) begin
			cur_reg <= cmd_frame;
			direct_reg <= cmd_direct;
		end
	end

	// Program counter and return stack
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= `PFA_PC_RESET;
			sp_reg <= '0;
		end else begin
			pc_reg <= pc_next;
			if (do_push) begin
				sp_reg <= sp_reg + `PFA_SP_STEP;
			end
		end
	end

	// Stack storage needs no reset; only entries below sp are ever valid
	always_ff @(posedge core_clk) begin
		if (do_push) begin
			stack_mem[sp_reg[2:0]] <= pc_reg;
		end
	end

	// User variables; the loop decrement wins over the load port
	always_ff @(posedge core_clk) begin
		if (loop_ok) begin
			uvar_mem[cur_reg.kind] <= dec_val;
		end else if (var_wr_en) begin
			uvar_mem[var_wr_idx] <= var_wr_data;
		end
	end

	// Last loop counter value for observation
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_var_reg <= '0;
		end else if (loop_ok) begin
			loop_var_reg <= dec_val;
		end
	end

	// Motion hand-over; a new move wins over an abort in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			target_pos_reg <= '0;
			pos_mode_reg <= 1'b0;
			move_start_reg <= 1'b0;
			moving_reg <= 1'b0;
		end else begin
			move_start_reg <= move_ok;
			if (move_ok) begin
				target_pos_reg <= move_dst;
				pos_mode_reg <= 1'b1;
				moving_reg <= 1'b1;
			end else if (motor_halt_cmd || spin_left_cmd || spin_right_cmd) begin
				moving_reg <= 1'b0;
				pos_mode_reg <= motor_halt_cmd;
			end
		end
	end

	// Reply one cycle after execution, direct frames only
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reply_reg <= '0;
		end else begin
			reply_reg.valid <= exec && direct_reg;
			if (exec && direct_reg) begin
				reply_reg.status <= status_next;
				reply_reg.instr <= cur_reg.instr;
				reply_reg.value <= accum;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_loop_jump: assert property (loop_ok && dec_val != `PFA_VAR_ZERO |=> pc_reg == $past(target))
		else $error("loop did not jump");
	a_loop_fall: assert property (loop_ok && dec_val == `PFA_VAR_ZERO
		|=> pc_reg == $past(pc_reg) + `PFA_PC_STEP)
		else $error("loop did not fall through");
	a_loop_dec: assert property (loop_ok
		|=> loop_var_reg == $past(uvar_mem[cur_reg.kind]) - `PFA_VAR_STEP)
		else $error("loop variable not decremented");
	a_call_push: assert property (call_ok && cond_ok && sp_reg < `PFA_STACK_DEPTH
		|=> sp_reg == $past(sp_reg) + `PFA_SP_STEP && pc_reg == $past(target))
		else $error("true call did not push");
	a_call_skip: assert property (call_ok && !cond_ok
		|=> $stable(sp_reg) && pc_reg == $past(pc_reg) + `PFA_PC_STEP)
		else $error("false call touched stack");
	a_stack_full: assert property (call_ok && sp_reg == `PFA_STACK_DEPTH
		|=> sp_reg == `PFA_STACK_DEPTH && pc_reg == $past(pc_reg) + `PFA_PC_STEP)
		else $error("full stack call not ignored");
	a_stack_bound: assert property (sp_reg <= `PFA_STACK_DEPTH)
		else $error("stack overflow");
	a_move_abs: assert property (move_ok && cur_reg.kind == `PFA_T_FIXED
		|=> target_pos_reg == $past(accum) && pos_mode_reg && move_start_reg)
		else $error("fixed move target wrong");
	a_move_rel: assert property (move_ok && cur_reg.kind == `PFA_T_OFFSET
		|=> target_pos_reg == $past(act_pos) + $past(accum))
		else $error("offset move target wrong");
	// Back-to-back frames are legal, so only the first cycle after execution is judged
	a_move_reply: assert property (move_ok && direct_reg
		|=> reply_reg.valid && reply_reg.status == `PFA_ST_OK && cmd_ready_reg)
		else $error("move reply missing");
	a_direct_block: assert property (exec && direct_reg && sum_ok
		&& (cur_reg.instr == `PFA_OP_CALL || cur_reg.instr == `PFA_OP_LOOP)
		|=> reply_reg.status == `PFA_ST_NOT_AVAIL && $stable(sp_reg) && $stable(pc_reg))
		else $error("direct call not refused");
	a_halt_abort: assert property (!move_ok && (motor_halt_cmd || spin_left_cmd || spin_right_cmd)
		|=> !moving_reg)
		else $error("abort did not stop move");
	a_ready_back: assert property (exec |=> cmd_ready_reg && !exec)
		else $error("ready not restored");

	c_loop_taken: cover property (loop_ok && dec_val != 0);
	c_call_nested: cover property (do_push && sp_reg == 7);
	c_call_full: cover property (call_ok && cond_ok && stack_full);
	c_move_direct: cover property (move_ok && direct_reg ##1 motor_halt_cmd);
endmodule : pfa_program_flow

// ==== rtl/pfa_regs.svh ====
// Purpose: Codes and constants of the program flow and accumulator move interpreter
// Assumes: One command frame of nine bytes, most significant value byte first
// Notes: Status codes other than OK have arbitrary but fixed values
`ifndef PFA_REGS_SVH
`define PFA_REGS_SVH
// Instruction codes
`define PFA_OP_LOOP 8'h31
`define PFA_OP_CALL 8'h15
`define PFA_OP_MOVE 8'h2E
// Call condition types
`define PFA_C_NULL 8'h00
`define PFA_C_NONNULL 8'h01
`define PFA_C_SAME 8'h02
`define PFA_C_DIFFER 8'h03
`define PFA_C_ABOVE 8'h04
`define PFA_C_ABOVE_SAME 8'h05
`define PFA_C_BELOW 8'h06
`define PFA_C_BELOW_SAME 8'h07
`define PFA_C_TIMEOUT 8'h08
`define PFA_C_ALARM 8'h09
`define PFA_C_DEVIATION 8'h0A
`define PFA_C_POSITION 8'h0B
// Move target types
`define PFA_T_FIXED 8'h00
`define PFA_T_OFFSET 8'h01
`define PFA_T_STORED 8'h02
// Reply status codes
`define PFA_ST_OK 8'h64
`define PFA_ST_BAD_SUM 8'h01
`define PFA_ST_BAD_CMD 8'h02
`define PFA_ST_BAD_TYPE 8'h03
`define PFA_ST_NOT_AVAIL 8'h06
// Return stack and counters
`define PFA_STACK_DEPTH 4'h8
`define PFA_SP_STEP 4'h1
`define PFA_PC_STEP 16'h0001
`define PFA_PC_RESET 16'h0000
`define PFA_VAR_STEP 32'h00000001
`define PFA_VAR_ZERO 32'h00000000
`endif

// ==== rtl/pfa_pkg.sv ====
// Purpose: Types shared by the interpreter and its bench
// Assumes: Frames arrive already assembled into bytes
// Notes: Value field is 32 bits, program counter 16 bits
package pfa_pkg;
	typedef logic [15:0] pfa_pc_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] instr;
		logic [7:0] kind;
		logic [7:0] bank;
		logic [31:0] value;
		logic [7:0] checksum;
	} pfa_frame_t;
	typedef struct packed {
		logic zero;
		logic equal;
		logic greater;
		logic lower;
		logic timeout_err;
		logic alarm_err;
		logic deviation_err;
		logic position_err;
	} pfa_flags_t;
	typedef struct packed {
		logic valid;
		logic [7:0] status;
		logic [7:0] instr;
		logic [31:0] value;
	} pfa_reply_t;
	typedef enum logic [1:0] {
		PFA_IDLE = 2'b00,
		PFA_EXEC = 2'b01
	} pfa_state_t;
endpackage : pfa_pkg

// ==== verification/pfa_src_model.sv ====
// Purpose: Frame source standing in for a host or a stored program
// Assumes: Frames are offered at the falling edge and held until taken
// Notes: Released frame lines carry the inverse of the last frame
`timescale 1ns/1ps
module pfa_src_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Command port
	input wire logic cmd_ready_reg,
	output logic cmd_valid,
	output logic cmd_direct,
	output pfa_pkg::pfa_frame_t cmd_frame
);
	// Idle lines start defined so nothing reads unknown
	initial begin
		cmd_valid = 1'b0;
		cmd_direct = 1'b0;
		cmd_frame = '1;
	end
	// One frame, held until ready is seen; a bad sum is off by one
	task automatic send(input logic [7:0] op, kind, input logic [31:0] val, input logic dir, bad);
		pfa_pkg::pfa_frame_t f;
		f = {8'h01, op, kind, 8'h00, val, 8'h00};
		f.checksum = f.addr + op + kind + f.bank + val[31:24] + val[23:16] + val[15:8] + val[7:0] + bad;
		@(negedge core_clk);
		// Nothing is offered while the block is held in reset
		while (rst_n !== 1'b1) begin
			@(negedge core_clk);
		end
		cmd_frame = f;
		cmd_direct = dir;
		cmd_valid = 1'b1;
		// No limit here; a hang is left to the bench watchdog, which fails the run
		while (cmd_ready_reg !== 1'b1) begin
			@(negedge core_clk);
		end
		@(negedge core_clk);
		cmd_valid = 1'b0;
		cmd_frame = ~f;
	endtask : send
endmodule : pfa_src_model

// ==== verification/tb.sv ====
// Purpose: Self-checking bench of the program flow interpreter
// Assumes: Effects show one edge after the take edge
// Notes: Stack is never popped here, so call tests run last
`timescale 1ns/1ps
`include "pfa_regs.svh"
module tb;
	logic core_clk, rst_n, cmd_valid, cmd_direct, cmd_ready_reg, var_wr_en;
	logic motor_halt_cmd, spin_left_cmd, spin_right_cmd, pos_mode_reg, move_start_reg, moving_reg;
	logic [31:0] accum, act_pos, stored_point_type_pos, var_wr_data, target_pos_reg, loop_var_reg;
	logic [7:0] var_wr_idx;
	logic [3:0] sp_reg;
	pfa_pkg::pfa_frame_t cmd_frame;
	pfa_pkg::pfa_reply_t reply_reg;
	pfa_pkg::pfa_flags_t flags;
	pfa_pkg::pfa_pc_t pc_reg, exp_pc;
	int error_cnt = 0;
	int n_checks = 0;
	// Flags that make each call type true, and flags that make it false
	logic [7:0] ct [12] = '{8'h80, 8'h00, 8'h40, 8'h00, 8'h20, 8'h40, 8'h10, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01};
	logic [7:0] cf [12] = '{8'h00, 8'h80, 8'h00, 8'h40, 8'h40, 8'h10, 8'h40, 8'h20, 8'hF7, 8'hFB, 8'hFD, 8'hFE};
	// Design and frame source
	pfa_program_flow i_dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_direct(cmd_direct), .cmd_frame(cmd_frame), .cmd_ready_reg(cmd_ready_reg),
		.reply_reg(reply_reg), .flags(flags), .accum(accum), .act_pos(act_pos), .stored_point_type_pos(stored_point_type_pos),
		.var_wr_en(var_wr_en), .var_wr_idx(var_wr_idx), .var_wr_data(var_wr_data),
		.motor_halt_cmd(motor_halt_cmd), .spin_left_cmd(spin_left_cmd), .spin_right_cmd(spin_right_cmd),
		.target_pos_reg(target_pos_reg), .pos_mode_reg(pos_mode_reg), .move_start_reg(move_start_reg),
		.moving_reg(moving_reg), .pc_reg(pc_reg), .sp_reg(sp_reg), .loop_var_reg(loop_var_reg));
	pfa_src_model i_src (.core_clk(core_clk), .rst_n(rst_n), .cmd_ready_reg(cmd_ready_reg),
		.cmd_valid(cmd_valid), .cmd_direct(cmd_direct), .cmd_frame(cmd_frame));
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Compare and count
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	// Send a frame and land on the falling edge where its effects stand
	task automatic run(input logic [7:0] op, kind, input logic [31:0] val, input logic dir, bad);
		i_src.send(op, kind, val, dir, bad);
		@(negedge core_clk);
	endtask : run
	task automatic t_move;
		int i;
		accum = 32'h00001234;
		act_pos = 32'h00000100;
		stored_point_type_pos = 32'h0000ABCD;
		run(`PFA_OP_MOVE, `PFA_T_FIXED, 32'hFFFFFFFF, 1'b1, 1'b0);
		check("fixed target", target_pos_reg, 32'h00001234);
		check("move flags", {pos_mode_reg, moving_reg, move_start_reg}, 3'b111);
		check("move reply", {reply_reg.valid, reply_reg.status, reply_reg.instr, reply_reg.value},
			{9'h164, 8'h2E, 32'h00001234});
		// Offsets stay far inside half the 32-bit range
		run(`PFA_OP_MOVE, `PFA_T_OFFSET, 32'h0, 1'b1, 1'b0);
		check("offset target", target_pos_reg, 32'h00001334);
		accum = 32'hFFFFFF00;
		run(`PFA_OP_MOVE, `PFA_T_OFFSET, 32'h0, 1'b1, 1'b0);
		check("back offset", target_pos_reg, 32'h00000000);
		accum = 32'h00001234;
		run(`PFA_OP_MOVE, `PFA_T_STORED, 32'h0, 1'b1, 1'b0);
		check("stored target", target_pos_reg, 32'h0000ABCD);
		run(`PFA_OP_MOVE, 8'h03, 32'h0, 1'b1, 1'b0);
		check("bad type", reply_reg.status, `PFA_ST_BAD_TYPE);
		run(`PFA_OP_MOVE, `PFA_T_FIXED, 32'h0, 1'b1, 1'b1);
		check("bad sum", {reply_reg.status, target_pos_reg}, {8'h01, 32'h0000ABCD});
		check("pc kept", pc_reg, 16'h0000);
		// Halt keeps position mode, spins drop it
		for (i = 0; i < 3; i++) begin
			run(`PFA_OP_MOVE, `PFA_T_FIXED, 32'h0, 1'b1, 1'b0);
			{motor_halt_cmd, spin_left_cmd, spin_right_cmd} = 3'b100 >> i;
			@(negedge core_clk);
			{motor_halt_cmd, spin_left_cmd, spin_right_cmd} = 3'b000;
			check("abort", {moving_reg, pos_mode_reg}, {1'b0, i == 0});
		end
		$display("move test done");
	endtask : t_move
	task automatic t_loop;
		var_wr_idx = 8'h2A;
		var_wr_data = 32'h00000002;
		var_wr_en = 1'b1;
		@(negedge core_clk);
		var_wr_en = 1'b0;
		run(`PFA_OP_LOOP, 8'h2A, 32'h00000040, 1'b0, 1'b0);
		check("loop var", loop_var_reg, 32'h1);
		check("loop jump", pc_reg, 16'h0040);
		run(`PFA_OP_LOOP, 8'h2A, 32'h00000050, 1'b0, 1'b0);
		check("loop end", {loop_var_reg, pc_reg}, {32'h0, 16'h0041});
		run(`PFA_OP_LOOP, 8'h2A, 32'h00000050, 1'b1, 1'b0);
		check("direct loop", {reply_reg.status, pc_reg}, {8'h06, 16'h0041});
		run(`PFA_OP_CALL, `PFA_C_NONNULL, 32'h00000050, 1'b1, 1'b0);
		check("direct call", {reply_reg.status, sp_reg}, {8'h06, 4'h0});
		exp_pc = 16'h0041;
		$display("loop test done");
	endtask : t_loop
	// Each type false then true; types 0 to 7 fill the stack, 8 to 11 are ignored,
	// then a mid-run reset empties it so types 8 to 11 can push as well
	task automatic t_call;
		int i;
		logic [7:0] t;
		logic [3:0] d;
		d = 4'h0;
		for (i = 0; i < 16; i++) begin
			t = (i < 12) ? 8'(i) : 8'(i - 4);
			if (i == 12) begin
				rst_n = 1'b0;
				repeat (3) @(negedge core_clk);
				check("mid reset", {pc_reg, sp_reg, cmd_ready_reg}, 21'h0);
				rst_n = 1'b1;
				{exp_pc, d} = '0;
			end
			flags = cf[t];
			run(`PFA_OP_CALL, t, 32'h00000200, 1'b0, 1'b0);
			exp_pc++;
			check("false call", {pc_reg, sp_reg}, {exp_pc, d});
			flags = ct[t];
			run(`PFA_OP_CALL, t, 32'h00000100 + i, 1'b0, 1'b0);
			if (d < 4'h8) begin
				d++;
				exp_pc = 16'(32'h100 + i);
			end else begin
				exp_pc++;
			end
			check("call pc", pc_reg, exp_pc);
			check("call depth", sp_reg, d);
		end
		// Unknown type is never met, whatever the flags
		flags = '1;
		run(`PFA_OP_CALL, 8'h0C, 32'h00000300, 1'b0, 1'b0);
		exp_pc++;
		check("unknown type", {pc_reg, sp_reg}, {exp_pc, d});
		$display("call test done");
	endtask : t_call
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{var_wr_en, motor_halt_cmd, spin_left_cmd, spin_right_cmd} = 4'h0;
		{accum, act_pos, stored_point_type_pos, var_wr_data} = '0;
		var_wr_idx = 8'h00;
		flags = '0;
		repeat (12) @(negedge core_clk);
		check("reset", {pc_reg, sp_reg, moving_reg, cmd_ready_reg}, 22'h0);
		rst_n = 1'b1;
		t_move;
		t_loop;
		t_call;
		stop_test;
	end
	// Watchdog
	initial begin
		#100us;
		error_cnt++;
		stop_test;
	end
endmodule : tb
